/* File: src/can_timing_flags.sv */
// bit timing, loopback, wake detection and receiver flags of the can controller
// assumes the rest of the controller supplies counts, passive flags and transmit stream
`timescale 1ns/1ps
`default_nettype none

module can_timing_flags
  import can_timing_pkg::*;
#(
  parameter int unsigned WAKE_CYCLES = WAKE_PULSE_CYC
)(
  input  wire logic                clk_i,
  input  wire logic                resetn_i,
  input  wire logic [ADDR_W-1:0]   avs_address_i,
  input  wire logic                avs_chipselect_bank_i,
  input  wire logic                avs_read_i,
  input  wire logic                avs_write_i,
  input  wire logic [31:0]         avs_writedata_i,
  input  wire logic [3:0]          avs_byteenable_i,
  output logic [31:0]              avs_readdata_o,
  output logic                     avs_waitrequest_o,
  input  wire logic                soft_reset_bit_i,
  input  wire logic                sleep_mode_i,
  input  wire logic [7:0]          rx_error_count_i,
  input  wire logic                tx_passive_flag_i,
  input  wire logic                bus_off_flag_i,
  input  wire logic [5:0]          other_flags_set_i,
  input  wire logic                pll_clock_tick_i,
  input  wire logic                crystal_clock_tick_i,
  input  wire logic                can_receive_pin_i,
  input  wire logic                tx_bit_i,
  input  wire logic                ack_slot_i,
  input  wire logic                tx_done_i,
  input  wire logic                rx_done_i,
  output logic                     can_transmit_pin_o,
  output logic                     rx_bit_o,
  output logic                     sample_tick_o,
  output logic                     bit_start_o,
  output logic                     tx_irq_o,
  output logic                     rx_irq_o,
  output logic                     error_irq_o,
  output logic                     wake_irq_o,
  output logic [3:0]               bit_quanta_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state carrier

  typedef struct packed {
    mode_s       mode;
    prescale_s   pre;
    segments_s   seg;
    logic [7:0]  flags;
    logic [7:0]  enables;
    logic        rx_sync1;
    logic        rx_sync2;
    logic        rx_prev;
    logic        mod_tick;
    logic        xtal_half;
    logic [5:0]  pre_cnt;
    seg_e        phase;
    logic [3:0]  tq_cnt;
    logic [2:0]  samples;
    logic        bus_bit;
    logic [15:0] wake_cnt;
    logic [31:0] rdata;
    logic        wait_n;
    logic        can_tx;
    logic        rx_out;
    logic        smp;
    logic        bstart;
    logic        tx_irq;
    logic        rx_irq;
    logic        err_irq;
    logic        wk_irq;
    logic [3:0]  quanta;
  } state_s;

  state_s st;
  state_s next_st;

  function automatic logic majority3(input logic [2:0] v);
    majority3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction : majority3

  function automatic logic [3:0] plus_one4(input logic [3:0] v);
    plus_one4 = v + 4'h1;
  endfunction : plus_one4

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic       access;
  logic       commit;
  logic       bank_ok;
  logic       wr_mode;
  logic       wr_pre;
  logic       wr_seg;
  logic       wr_flags;
  logic       wr_en;
  logic       rx_line;
  logic       sampled;
  logic [7:0] set_now;
  logic [7:0] cond_now;
  logic [7:0] clr_mask;
  logic       falling;

  always_comb
  begin
    next_st  = st;
    sampled  = 1'b0;
    access   = (avs_read_i | avs_write_i) & ~st.wait_n;
    commit   = avs_write_i & st.wait_n;
    bank_ok  = avs_chipselect_bank_i == BANK_LOW[0];
    wr_mode  = commit & bank_ok & (avs_address_i == OFS_MODE_CTRL);
    wr_pre   = commit & bank_ok & (avs_address_i == OFS_TIMING_PRE);
    wr_seg   = commit & bank_ok & (avs_address_i == OFS_TIMING_SEG);
    wr_flags = commit & bank_ok & (avs_address_i == OFS_RX_FLAGS);
    wr_en    = commit & ~bank_ok & (avs_address_i == OFS_IRQ_ENABLE);
    next_st.rx_sync1 = can_receive_pin_i;
    next_st.rx_sync2 = st.rx_sync1;
    rx_line = st.mode.loopback_selftest ? tx_bit_i : st.rx_sync2;
    next_st.can_tx = st.mode.loopback_selftest ? 1'b1 : tx_bit_i;
    next_st.xtal_half = st.xtal_half ^ crystal_clock_tick_i;
    next_st.mod_tick = st.mode.module_clock_select ? pll_clock_tick_i
                                                   : (crystal_clock_tick_i & st.xtal_half);
    next_st.smp    = 1'b0;
    next_st.bstart = 1'b0;
    next_st.quanta = 4'h1 + plus_one4(st.seg.first_time_segment)
                     + plus_one4({1'b0, st.seg.second_time_segment});
    if (soft_reset_bit_i && wr_mode && avs_byteenable_i[0])
    begin
      next_st.mode = avs_writedata_i[2:0];
    end
    if (soft_reset_bit_i && wr_pre && avs_byteenable_i[0])
    begin
      next_st.pre = avs_writedata_i[7:0];
    end
    if (soft_reset_bit_i && wr_seg && avs_byteenable_i[0])
    begin
      next_st.seg = avs_writedata_i[7:0];
    end
    if (soft_reset_bit_i)
    begin
      next_st.phase   = SEG_SYNC;
      next_st.pre_cnt = 6'h00;
      next_st.tq_cnt  = 4'h0;
    end
    else if (st.mod_tick)
    begin
      if (st.pre_cnt >= st.pre.baud_prescaler)
      begin
        next_st.pre_cnt = 6'h00;
        next_st.samples = {st.samples[1:0], rx_line};
        case (st.phase)
          SEG_SYNC:
          begin
            next_st.phase  = SEG_ONE;
            next_st.tq_cnt = 4'h0;
          end
          SEG_ONE:
          begin
            if (st.tq_cnt >= st.seg.first_time_segment)
            begin
              next_st.phase  = SEG_TWO;
              next_st.tq_cnt = 4'h0;
              next_st.smp    = 1'b1;
              sampled = st.seg.triple_sample ? majority3({st.samples[1:0], rx_line}) : rx_line;
              if (ack_slot_i && st.mode.loopback_selftest)
              begin
                sampled = 1'b0;
              end
              next_st.bus_bit = sampled;
              next_st.rx_out  = sampled;
            end
            else
            begin
              next_st.tq_cnt = st.tq_cnt + 4'h1;
            end
          end
          SEG_TWO:
          begin
            if (st.tq_cnt >= {1'b0, st.seg.second_time_segment})
            begin
              next_st.phase  = SEG_SYNC;
              next_st.bstart = 1'b1;
            end
            else
            begin
              next_st.tq_cnt = st.tq_cnt + 4'h1;
            end
          end
          default:
          begin
            next_st.phase = SEG_SYNC;
          end
        endcase
      end
      else
      begin
        next_st.pre_cnt = st.pre_cnt + 6'h01;
      end
    end
    falling = st.rx_prev & ~st.rx_sync2;
    next_st.rx_prev = st.rx_sync2;
    if (st.rx_sync2)
    begin
      next_st.wake_cnt = 16'h0000;
    end
    else if (st.wake_cnt < 16'(WAKE_CYCLES))
    begin
      next_st.wake_cnt = st.wake_cnt + 16'h0001;
    end
    cond_now = 8'h00;
    cond_now[7] = sleep_mode_i & (st.mode.wake_filter_mode
                  ? (st.wake_cnt == 16'(WAKE_CYCLES - 1)) & ~st.rx_sync2 : falling);
    cond_now[6] = (rx_error_count_i >= 8'(WARN_LEVEL)) & ~st.flags[4] & ~tx_passive_flag_i
                  & ~bus_off_flag_i;
    cond_now[4] = (rx_error_count_i > 8'(PASSIVE_LEVEL)) & ~bus_off_flag_i;
    cond_now[5] = other_flags_set_i[5];
    cond_now[3:0] = other_flags_set_i[3:0];
    set_now = cond_now;
    clr_mask = (wr_flags && avs_byteenable_i[0]) ? avs_writedata_i[7:0] : 8'h00;
    next_st.flags = (st.flags & ~(clr_mask & ~cond_now)) | set_now;
    if (wr_en && avs_byteenable_i[0])
    begin
      next_st.enables = avs_writedata_i[7:0];
    end
    if (soft_reset_bit_i)
    begin
      next_st.flags   = 8'h00;
      next_st.enables = 8'h00;
    end
    next_st.err_irq = |(st.flags & st.enables & ERROR_CLASS);
    next_st.wk_irq  = |(st.flags & st.enables & FLAG_WAKE);
    // rx and tx events kept in loopback
    next_st.tx_irq = tx_done_i & ~soft_reset_bit_i;
    next_st.rx_irq = rx_done_i & ~soft_reset_bit_i;
    // bus answer one cycle after request
    next_st.wait_n = access;
    next_st.rdata  = READ_UNMAPPED;
    if (access && avs_read_i)
    begin
      if (bank_ok)
      begin
        case (avs_address_i)
          OFS_MODE_CTRL:  next_st.rdata = {29'h0000_0000, st.mode};
          OFS_TIMING_PRE: next_st.rdata = {24'h00_0000, st.pre};
          OFS_TIMING_SEG: next_st.rdata = {24'h00_0000, st.seg};
          OFS_RX_FLAGS:   next_st.rdata = {24'h00_0000, st.flags};
          default:        next_st.rdata = READ_UNMAPPED;
        endcase
      end
      else if (avs_address_i == OFS_IRQ_ENABLE)
      begin
        next_st.rdata = {24'h00_0000, st.enables};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      st          <= '0;
      st.rx_sync1 <= 1'b1;
      st.rx_sync2 <= 1'b1;
      st.rx_prev  <= 1'b1;
      st.can_tx   <= 1'b1;
      st.rx_out   <= 1'b1;
      st.bus_bit  <= 1'b1;
      st.samples  <= 3'h7;
      st.quanta   <= 4'h2;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign avs_readdata_o     = st.rdata;
  assign avs_waitrequest_o  = ~st.wait_n;
  assign can_transmit_pin_o = st.can_tx;
  assign rx_bit_o           = st.rx_out;
  assign sample_tick_o      = st.smp;
  assign bit_start_o        = st.bstart;
  assign tx_irq_o           = st.tx_irq;
  assign rx_irq_o           = st.rx_irq;
  assign error_irq_o        = st.err_irq;
  assign wake_irq_o         = st.wk_irq;
  assign bit_quanta_o       = st.quanta;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  loop_tx_high_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $past(st.mode.loopback_selftest) |-> can_transmit_pin_o)
    else $error("transmit pin not recessive in loopback");

  mode_lock_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !soft_reset_bit_i |=> $stable(st.mode) && $stable(st.pre) && $stable(st.seg))
    else $error("timing changed outside soft reset");

  soft_clear_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    soft_reset_bit_i |=> st.flags == 8'h00)
    else $error("flags not cleared in soft reset");

  hold_clear_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    cond_now[4] && !soft_reset_bit_i |=> st.flags[4])
    else $error("passive flag lost while condition held");

  passive_set_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rx_error_count_i > 8'(PASSIVE_LEVEL) && !bus_off_flag_i && !soft_reset_bit_i |=> st.flags[4])
    else $error("passive flag not set");

  err_irq_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    |(st.flags & st.enables & ERROR_CLASS) |=> error_irq_o)
    else $error("error request missing");

  wake_set_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    sleep_mode_i && !st.mode.wake_filter_mode && falling && !soft_reset_bit_i |=> st.flags[7])
    else $error("wake flag not set on edge");

  w1c_clear_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr_flags && avs_byteenable_i[0] && avs_writedata_i[6] && !cond_now[6] |=> !st.flags[6])
    else $error("warning flag not cleared");

  sequence loop_ack_seq;
    st.mode.loopback_selftest && ack_slot_i && next_st.smp;
  endsequence

  sequence rx_dominant_seq;
    !rx_bit_o;
  endsequence

  sequence quiet_seq;
    !bit_start_o && !sample_tick_o;
  endsequence

  sequence short_low_seq;
    sleep_mode_i && st.mode.wake_filter_mode && !st.flags[7]
    && st.wake_cnt < 16'(WAKE_CYCLES - 1);
  endsequence

  loop_ack_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    loop_ack_seq |=> rx_dominant_seq)
    else $error("acknowledge slot not read as dominant");

  soft_quiet_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    soft_reset_bit_i |=> quiet_seq)
    else $error("bit timing ran in soft reset");

  wake_filter_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    short_low_seq |=> !st.flags[7])
    else $error("wake flag set by short pulse");

  wake_irq_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    st.flags[7] && st.enables[7] |=> wake_irq_o)
    else $error("wake request missing");

endmodule : can_timing_flags

`default_nettype wire

/* File: pkg/can_timing_pkg.sv */
// constants, field layouts and carrier types for the can timing and receiver flag slice
// assumes an avalon-mm master with 32-bit data and a single 100 MHz clock
//
// Summary of operation
// - loopback feeds transmit stream into receiver
// - loopback ignores receive pin, transmit recessive; wake detection still reads the pin
// - loopback ignores acknowledge slot bit value
// - loopback still raises transmit and receive interrupts
// - filtered wake needs dominant pulse minimum length
// - unfiltered wake on any falling bus edge
// - clock select: pll clock or crystal half
// - mode and timing writable only in soft reset
// - jump width is field plus one quanta; field is only stored and read back, no resynchronization uses it
// - prescaler divides by field plus one
// - triple sample takes majority of three
// - first segment is field plus one quanta
// - second segment is field plus one quanta
// - bit time is prescale times total quanta
// - receiver flags clear by writing one
// - clear ignored while set condition holds
// - hard and soft reset clear flags
// - flag interrupt needs flag and enable
// - sleep bus activity sets wake flag
// - warning flag at count 96, no passive
// - soft reset aborts, holds flags reset
// - receive passive above 127 unless bus off
package can_timing_pkg;

  localparam int unsigned ADDR_W          = 4;
  localparam logic [3:0]  OFS_MODE_CTRL   = 4'h0;
  localparam logic [3:0]  OFS_TIMING_PRE  = 4'h4;
  localparam logic [3:0]  OFS_TIMING_SEG  = 4'h8;
  localparam logic [3:0]  OFS_RX_FLAGS    = 4'hc;
  localparam logic [3:0]  OFS_IRQ_ENABLE  = 4'h0;
  localparam logic [1:0]  BANK_LOW        = 2'h0;
  localparam logic [1:0]  BANK_HIGH       = 2'h1;
  localparam logic [31:0] READ_UNMAPPED   = 32'h0000_0000;

  localparam int unsigned WARN_LEVEL      = 96;
  localparam int unsigned PASSIVE_LEVEL   = 127;
  localparam int unsigned MIN_FIRST_TIME_SEGMENT_CODE  = 3;
  localparam int unsigned MIN_SECOND_TIME_SEGMENT_CODE  = 1;

  localparam int unsigned WAKE_PULSE_NS   = 2000;
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned WAKE_PULSE_CYC  = (WAKE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [7:0]  FLAG_WAKE       = 8'h80;
  localparam logic [7:0]  FLAG_RX_WARN    = 8'h40;
  localparam logic [7:0]  FLAG_RX_PASSIVE = 8'h10;
  localparam logic [7:0]  ERROR_CLASS     = 8'h7e;

  typedef struct packed {
    logic       loopback_selftest;
    logic       wake_filter_mode;
    logic       module_clock_select;
  } mode_s;

  typedef struct packed {
    logic [1:0] resync_jump_width;
    logic [5:0] baud_prescaler;
  } prescale_s;

  typedef struct packed {
    logic       triple_sample;
    logic [2:0] second_time_segment;
    logic [3:0] first_time_segment;
  } segments_s;

  typedef enum logic [1:0] {
    SEG_SYNC,
    SEG_ONE,
    SEG_TWO
  } seg_e;

endpackage : can_timing_pkg

/* File: test/can_bus_node.sv */
// remote can node that pulls the shared bus dominant on command
// assumes a recessive-high bus where any dominant driver wins
`timescale 1ns/1ps
`default_nettype none

module can_bus_node (
  input  wire logic       clk_i,
  input  wire logic       send_i,
  input  wire logic [7:0] len_i,
  input  wire logic       tx_pin_i,
  output logic            rx_pin_o
);
  logic [7:0] left = 8'h00;

  // dominant for len_i cycles after send_i
  always_ff @(posedge clk_i)
  begin
    if (send_i)
      left <= len_i;
    else if (left != 8'h00)
      left <= left - 8'h01;
  end

  // wired-and of own transmitter and remote node
  assign rx_pin_o = tx_pin_i & (left == 8'h00);
endmodule : can_bus_node

`default_nettype wire

/* File: test/can_timing_flags_tb.sv */
// self-checking bench for the can timing and receiver flag slice
// assumes a 100 MHz clock and a remote node model on the bus pin
`timescale 1ns/1ps
`default_nettype none

module can_timing_flags_tb
  import can_timing_pkg::*;
;
  logic        clk_i = 1'b0, resetn_i = 1'b0, send = 1'b0;
  logic [3:0]  avs_address_i = 4'h0, bit_quanta_o;
  logic        avs_chipselect_bank_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0000_0000, avs_readdata_o;
  logic        avs_waitrequest_o, soft_reset_bit_i = 1'b0, sleep_mode_i = 1'b0;
  logic [7:0]  rx_error_count_i = 8'h00, plen = 8'h00;
  logic        tx_passive_flag_i = 1'b0, bus_off_flag_i = 1'b0, tx_done_i = 1'b0;
  logic        tx_bit_i = 1'b1, ack_slot_i = 1'b0, rx_done_i = 1'b0, can_receive_pin_i;
  logic        can_transmit_pin_o, rx_bit_o, sample_tick_o, bit_start_o;
  logic        tx_irq_o, rx_irq_o, error_irq_o, wake_irq_o;
  logic [7:0]  cm[3] = '{8'h01, 8'h00, 8'h01};
  logic [7:0]  cp[3] = '{8'hc1, 8'h01, 8'h3f};
  logic [7:0]  cs[3] = '{8'h13, 8'h93, 8'h7f};
  logic [15:0] cper[3] = '{16'h000e, 16'h001c, 16'h0640};
  logic [3:0]  cq[3] = '{4'h7, 4'h7, 4'h9};
  int          fail_count = 0, samples_checked = 0, c = 0, s = 0;

  initial
  begin
    forever #5 clk_i = ~clk_i;
  end

  can_timing_flags #(.WAKE_CYCLES(5)) DUT (
    .clk_i, .resetn_i, .avs_address_i, .avs_chipselect_bank_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i(4'hf), .avs_readdata_o, .avs_waitrequest_o,
    .soft_reset_bit_i, .sleep_mode_i, .rx_error_count_i, .tx_passive_flag_i, .bus_off_flag_i,
    .other_flags_set_i(6'h00), .pll_clock_tick_i(1'b1), .crystal_clock_tick_i(1'b1),
    .can_receive_pin_i, .tx_bit_i, .ack_slot_i, .tx_done_i, .rx_done_i, .can_transmit_pin_o,
    .rx_bit_o, .sample_tick_o, .bit_start_o, .tx_irq_o, .rx_irq_o, .error_irq_o, .wake_irq_o,
    .bit_quanta_o
  );

  can_bus_node node (
    .clk_i, .send_i(send), .len_i(plen), .tx_pin_i(can_transmit_pin_o),
    .rx_pin_o(can_receive_pin_i)
  );

  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: saw %0h want %0h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  task automatic give_up();
    fail_count++;
    test_done();
  endtask : give_up

  task automatic acc(input logic w, b, input logic [3:0] a, input logic [7:0] d, e);
    int n;
    avs_chipselect_bank_i <= b;
    avs_address_i <= a;
    avs_writedata_i <= {24'h00_0000, d};
    avs_write_i <= w;
    avs_read_i <= ~w;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (avs_waitrequest_o !== 1'b0 && n < 40);
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (n >= 40)
      give_up();
    if (!w)
      check(avs_readdata_o, {24'h00_0000, e});
    @(posedge clk_i);
  endtask : acc

  task automatic rdf(input logic [7:0] e);
    repeat (3) @(posedge clk_i);
    acc(1'b0, 1'b0, OFS_RX_FLAGS, 8'h00, e);
  endtask : rdf

  task automatic wrf(input logic b, input logic [7:0] d);
    acc(1'b1, b, OFS_RX_FLAGS & {4{~b}}, d, 8'h00);
  endtask : wrf

  task automatic cfg(input logic [7:0] m, p, s);
    soft_reset_bit_i <= 1'b1;
    acc(1'b1, 1'b0, OFS_MODE_CTRL, m, 8'h00);
    acc(1'b1, 1'b0, OFS_TIMING_PRE, p, 8'h00);
    acc(1'b1, 1'b0, OFS_TIMING_SEG, s, 8'h00);
    soft_reset_bit_i <= 1'b0;
    acc(1'b1, 1'b0, OFS_MODE_CTRL, ~m, 8'h00);
    acc(1'b0, 1'b0, OFS_MODE_CTRL, 8'h00, m);
    acc(1'b0, 1'b0, OFS_TIMING_PRE, 8'h00, p);
    acc(1'b0, 1'b0, OFS_TIMING_SEG, 8'h00, s);
  endtask : cfg

  task automatic bus_pulse(input logic [7:0] n, input int w);
    send <= 1'b1;
    plen <= n;
    @(posedge clk_i);
    send <= 1'b0;
    repeat (w) @(posedge clk_i);
  endtask : bus_pulse

  task automatic period();
    repeat (2)
    begin
      c = 0;
      s = 0;
      do
      begin
        @(posedge clk_i);
        c++;
        s += int'(sample_tick_o === 1'b1);
      end
      while (bit_start_o !== 1'b1 && c < 20000);
      if (c >= 20000)
        give_up();
    end
  endtask : period

  ////////////////////////////////////////
  initial
  begin
    repeat (5) @(posedge clk_i);
    check({error_irq_o, wake_irq_o}, 2'b00);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    rdf(8'h00);
    acc(1'b0, 1'b1, 4'h4, 8'h00, 8'h00);
    // bit period over clock source, prescaler and segment bounds
    for (int i = 0; i < 3; i++)
    begin
      cfg(cm[i], cp[i], cs[i]);
      period();
      check(c, {16'h0000, cper[i]});
      check(bit_quanta_o, cq[i]);
      check(s, 1);
    end
    // warning at threshold, blocked by passive
    rx_error_count_i <= 8'h60;
    tx_passive_flag_i <= 1'b1;
    rdf(8'h00);
    tx_passive_flag_i <= 1'b0;
    rdf(FLAG_RX_WARN);
    wrf(1'b1, FLAG_RX_WARN);
    repeat (3) @(posedge clk_i);
    check(error_irq_o, 1'b1);
    wrf(1'b0, FLAG_RX_WARN);
    rdf(FLAG_RX_WARN);
    rx_error_count_i <= 8'h00;
    wrf(1'b0, 8'h00);
    rdf(FLAG_RX_WARN);
    wrf(1'b0, FLAG_RX_WARN);
    rdf(8'h00);
    check(error_irq_o, 1'b0);
    rx_error_count_i <= 8'h82;
    tx_passive_flag_i <= 1'b1;
    bus_off_flag_i <= 1'b1;
    rdf(8'h00);
    bus_off_flag_i <= 1'b0;
    rdf(FLAG_RX_PASSIVE);
    check(error_irq_o, 1'b0);
    wrf(1'b1, FLAG_RX_PASSIVE);
    repeat (3) @(posedge clk_i);
    check(error_irq_o, 1'b1);
    soft_reset_bit_i <= 1'b1;
    rdf(8'h00);
    check(error_irq_o, 1'b0);
    rx_error_count_i <= 8'h00;
    tx_passive_flag_i <= 1'b0;
    // filtered and unfiltered wake in sleep
    cfg(8'h02, 8'h01, 8'h13);
    sleep_mode_i <= 1'b1;
    wrf(1'b1, FLAG_WAKE);
    bus_pulse(8'h03, 10);
    rdf(8'h00);
    bus_pulse(8'h0c, 20);
    rdf(FLAG_WAKE);
    check(wake_irq_o, 1'b1);
    wrf(1'b0, FLAG_WAKE);
    rdf(8'h00);
    cfg(8'h00, 8'h01, 8'h13);
    bus_pulse(8'h01, 8);
    rdf(FLAG_WAKE);
    check(wake_irq_o, 1'b0);
    // loopback with a dominant remote node
    sleep_mode_i <= 1'b0;
    cfg(8'h05, 8'h00, 8'h13);
    tx_bit_i <= 1'b0;
    repeat (30) @(posedge clk_i);
    check(can_transmit_pin_o, 1'b1);
    check(rx_bit_o, 1'b0);
    tx_bit_i <= 1'b1;
    ack_slot_i <= 1'b1;
    repeat (30) @(posedge clk_i);
    check(rx_bit_o, 1'b0);
    ack_slot_i <= 1'b0;
    bus_pulse(8'h28, 30);
    check(rx_bit_o, 1'b1);
    tx_done_i <= 1'b1;
    rx_done_i <= 1'b1;
    @(posedge clk_i);
    tx_done_i <= 1'b0;
    rx_done_i <= 1'b0;
    @(posedge clk_i);
    check({tx_irq_o, rx_irq_o}, 2'b11);
    test_done();
  end
endmodule : can_timing_flags_tb

`default_nettype wire
